/* logic/adc_irq_defs.svh */
// Register offsets, bit positions, reset values and timing figures
`ifndef ADC_IRQ_DEFS_SVH
`define ADC_IRQ_DEFS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_SIG_DET_STATUS 8'h32
`define OFS_LOSS_TIMEOUT 8'h33
`define OFS_DET_INTERVAL 8'h36
`define OFS_INT_ENABLE 8'h60
`define OFS_INT_STATUS 8'h61
`define OFS_PULSE_CONFIG 8'h62
`define OFS_POWER_DOWN 8'h70
`define OFS_PIN_CFG0 8'h14
`define OFS_PIN_STATUS 8'h18
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SRC_ENERGY 0
`define SRC_DC 1
`define SRC_TOGGLE 2
`define SRC_CLIP 5
`define SLEEP_BIT 0
`define LOSS_BIT 0
`define NO_TOGGLE_PIN 2
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_INT_ENABLE 8'h01
`define RST_LOSS_TIMEOUT 8'h01
`define RST_DET_INTERVAL 8'h01
`define RST_PULSE_CONFIG 8'h00
`define RST_POWER_DOWN 8'h00
`define RST_PIN_CFG 8'h00
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 50
`define MS_NS 1000000
`define CYC_PER_MS (`MS_NS / `CLK_PERIOD_NS)
`define MS_PER_MIN 60000
`define MS_PER_SEC 1000
`endif

/* logic/adc_irq_pkg.sv */
// Types shared by the interrupt controller and its bench
package adc_irq_pkg;
   typedef enum logic [1:0] {
      DRIVE_HIGH = 2'h0,
      DRIVE_LOW = 2'h1,
      DRIVE_OPEN = 2'h2
   } pin_drive_type;

   typedef struct packed {
      logic [2:0] spare;
      logic sticky;
      pin_drive_type drive;
      logic [1:0] width;
   } pulse_cfg_type;

   typedef struct packed {
      logic [2:0] spare;
      logic open_drain;
      logic int_out;
      logic invert;
      logic [1:0] func;
   } pin_cfg_type;

   typedef enum logic [2:0] {
      PS_IDLE = 3'b001,
      PS_PULSE = 3'b010,
      PS_HOLD = 3'b100
   } pulse_state_type;
endpackage

/* logic/adc_event_irq.sv */
// Event interrupt controller of a multichannel audio converter
//
// Function
// - Four sources: energy, dc change, clip, toggle
// - Enable bit gates each source
// - Status register holds one flag per source
// - Status write clears addressed flags
// - Pin drive: high, low or open collector
// - Pulse width one to four milliseconds
// - Pin pulses, or holds while flags set when sticky; flags stay sticky
// - Drive variants share all register behaviour
// - Toggle detect on every pin but pin 2
// - Toggle detect only while asleep
// - Pin variant: energy source only, default
// - Pin variant: interrupt pin requests power-down
// - Active energy flag cleared after detect status
// - Detect status all-ones write clears to zero
// - Loss raised after programmed timeout below threshold
// - Entering sleep clears sticky loss status
// - Pin types: input, toggle, sticky; inversion
// - Pins can drive interrupt open drain
// - Duration: pulsed or sticky until cleared
// - Uncleared loss re-raised every interval
`timescale 1ns/10ps
`include "adc_irq_defs.svh"

module adc_event_irq import adc_irq_pkg::*; #(
   parameter bit HW_VARIANT = 1'b0,
   parameter int NPINS = 4,
   parameter int CYC_PER_MS = `CYC_PER_MS,
   parameter int MS_PER_MIN = `MS_PER_MIN,
   parameter int MS_PER_SEC = `MS_PER_SEC
) (
   input wire logic clk_i, // Device clock
   input wire logic rstn_i, // Async reset
   input wire logic reg_wr_i, // Register write
   input wire logic reg_rd_i, // Register read
   input wire logic [7:0] reg_addr_i, // Register offset
   input wire logic [7:0] reg_wdata_i, // Write data
   output logic [7:0] reg_rdata_o, // Read data
   input wire logic audio_clk_run_i, // Audio clocks run
   input wire logic loss_below_i, // Level below loss
   input wire logic [7:0] resume_det_i, // Channels above wake
   input wire logic dc_change_i, // Dc level changed
   input wire logic clip_i, // Post-gain clip
   input wire logic [NPINS-1:0] pin_in_i, // Pin levels
   input wire logic int_in_i, // Interrupt pin level
   output logic int_o, // Interrupt pin out
   output logic int_oe_o, // Interrupt pin enable
   output logic [NPINS-1:0] pin_o, // Pin outputs
   output logic [NPINS-1:0] pin_oe_o, // Pin enables
   output logic power_down_o, // Power-down request
   output logic sleep_o // Sleep mode
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Set beats clear in the same cycle
   function automatic logic [7:0] w1c(input logic [7:0] cur,
      input logic [7:0] set, input logic [7:0] clr);
      return set | (cur & ~clr);
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [7:0] int_en, next_int_en;
   logic [7:0] int_stat, next_int_stat;
   logic [7:0] sig_det, next_sig_det;
   logic [7:0] pwr, next_pwr;
   logic [7:0] loss_timeout, next_loss_timeout;
   logic [7:0] det_interval, next_det_interval;
   pulse_cfg_type pcfg, next_pcfg;
   pin_cfg_type pin_cfg [NPINS];
   pin_cfg_type next_pin_cfg [NPINS];
   logic [NPINS-1:0] pin_q, next_pin_q;
   logic [NPINS-1:0] pin_stk, next_pin_stk;
   logic [1:0] src_q, next_src_q;
   logic sleep_q;
   logic [7:0] next_rdata;
   logic [23:0] ms_cnt, next_ms_cnt;
   logic [23:0] loss_ms, next_loss_ms;
   logic [23:0] pcyc, next_pcyc;
   pulse_state_type pstate, next_pstate;
   logic next_int_o, next_int_oe;
   logic [NPINS-1:0] next_pin_o, next_pin_oe;
   logic next_pdown;
   logic sleep, loss_fire, trig, tick, asserted;
   logic [7:0] ev, en_eff;

   // Audio clocks stopped also means sleep
   assign sleep = pwr[`SLEEP_BIT] | ~audio_clk_run_i;

   // ----------------------------------------
   // Registers and flags
   // ----------------------------------------
   // Register file, event capture and flags
   always_comb begin
      logic [7:0] clr;
      logic [7:0] lvl;
      logic [7:0] stk;
      logic tog;
      clr = 8'h00;
      lvl = 8'h00;
      stk = 8'h00;
      tog = 1'b0;
      next_int_en = int_en;
      next_pwr = pwr;
      next_loss_timeout = loss_timeout;
      next_det_interval = det_interval;
      next_pcfg = pcfg;
      next_pin_cfg = pin_cfg;
      next_rdata = reg_rdata_o;
      if (reg_wr_i) begin
         case (reg_addr_i)
            `OFS_INT_ENABLE: next_int_en = reg_wdata_i;
            `OFS_PULSE_CONFIG: next_pcfg = pulse_cfg_type'(reg_wdata_i);
            `OFS_POWER_DOWN: next_pwr = reg_wdata_i;
            `OFS_LOSS_TIMEOUT: next_loss_timeout = reg_wdata_i;
            `OFS_DET_INTERVAL: next_det_interval = reg_wdata_i;
            default: begin
               for (int i = 0; i < NPINS; i++) begin
                  if (reg_addr_i == `OFS_PIN_CFG0 + 8'(i)) begin
                     next_pin_cfg[i] = pin_cfg_type'(reg_wdata_i);
                  end
               end
            end
         endcase
      end
      // Pins: inversion, toggle and sticky types
      for (int i = 0; i < NPINS; i++) begin
         lvl[i] = pin_in_i[i] ^ pin_cfg[i].invert;
         if (pin_cfg[i].func == 2'h1 && i != `NO_TOGGLE_PIN &&
               sleep && lvl[i] != pin_q[i]) begin
            tog = 1'b1;
         end
         stk[i] = pin_cfg[i].func == 2'h2 && lvl[i];
      end
      next_pin_q = lvl[NPINS-1:0];
      if (reg_wr_i && reg_addr_i == `OFS_PIN_STATUS) begin
         clr = reg_wdata_i >> 4;
      end
      next_pin_stk = NPINS'(w1c(8'(pin_stk), stk, clr));
      // Raw events; only the energy source in pin variant
      next_src_q = {clip_i, dc_change_i};
      ev = 8'h00;
      ev[`SRC_ENERGY] = sleep ? (sleep_q &&
         |(resume_det_i & ~sig_det)) : loss_fire;
      ev[`SRC_DC] = dc_change_i & ~src_q[0];
      ev[`SRC_TOGGLE] = tog;
      ev[`SRC_CLIP] = clip_i & ~src_q[1];
      en_eff = HW_VARIANT ? `RST_INT_ENABLE : int_en;
      ev = ev & en_eff;
      trig = |ev;
      // Detect status: live when asleep, sticky loss when active
      clr = 8'h00;
      if (reg_wr_i && reg_addr_i == `OFS_SIG_DET_STATUS) begin
         clr = reg_wdata_i;
      end
      if (sleep) begin
         next_sig_det = resume_det_i;
      end else begin
         next_sig_det = w1c(sig_det,
            8'(loss_fire) << `LOSS_BIT, clr);
      end
      // Status clear; energy held while awake and detect status set
      clr = 8'h00;
      if (reg_wr_i && reg_addr_i == `OFS_INT_STATUS) begin
         clr = reg_wdata_i;
      end
      if (!sleep && sig_det != 8'h00) begin
         clr[`SRC_ENERGY] = 1'b0;
      end
      if (sleep && !sleep_q) begin
         clr[`SRC_ENERGY] = 1'b1;
      end
      if (int_en[`SRC_CLIP] && !next_int_en[`SRC_CLIP]) begin
         clr[`SRC_CLIP] = 1'b1; // Disable clears clip flag
      end
      next_int_stat = w1c(int_stat, ev, clr);
      // Read data is registered, answered next cycle
      if (reg_rd_i) begin
         case (reg_addr_i)
            `OFS_SIG_DET_STATUS: next_rdata = sig_det;
            `OFS_LOSS_TIMEOUT: next_rdata = loss_timeout;
            `OFS_DET_INTERVAL: next_rdata = det_interval;
            `OFS_INT_ENABLE: next_rdata = int_en;
            `OFS_INT_STATUS: next_rdata = int_stat;
            `OFS_PULSE_CONFIG: next_rdata = pcfg;
            `OFS_POWER_DOWN: next_rdata = pwr;
            `OFS_PIN_STATUS: begin
               next_rdata = 8'({pin_stk, 4'h0}) | 8'(pin_q);
            end
            default: begin
               next_rdata = 8'h00;
               for (int i = 0; i < NPINS; i++) begin
                  if (reg_addr_i == `OFS_PIN_CFG0 + 8'(i)) begin
                     next_rdata = pin_cfg[i];
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         int_en <= `RST_INT_ENABLE;
         int_stat <= 8'h00;
         sig_det <= 8'h00;
         pwr <= `RST_POWER_DOWN;
         loss_timeout <= `RST_LOSS_TIMEOUT;
         det_interval <= `RST_DET_INTERVAL;
         pcfg <= pulse_cfg_type'(`RST_PULSE_CONFIG);
         for (int i = 0; i < NPINS; i++) begin
            pin_cfg[i] <= pin_cfg_type'(`RST_PIN_CFG);
         end
         pin_q <= '0;
         pin_stk <= '0;
         src_q <= 2'h0;
         sleep_q <= 1'b0;
         reg_rdata_o <= 8'h00;
         sleep_o <= 1'b0;
      end else begin
         int_en <= next_int_en;
         int_stat <= next_int_stat;
         sig_det <= next_sig_det;
         pwr <= next_pwr;
         loss_timeout <= next_loss_timeout;
         det_interval <= next_det_interval;
         pcfg <= next_pcfg;
         pin_cfg <= next_pin_cfg;
         pin_q <= next_pin_q;
         pin_stk <= next_pin_stk;
         src_q <= next_src_q;
         sleep_q <= sleep;
         reg_rdata_o <= next_rdata;
         sleep_o <= sleep;
      end
   end

   // ----------------------------------------
   // Timers, pulse and pins
   // ----------------------------------------
   // Millisecond tick, loss timer, pulse state and drive
   always_comb begin
      logic [23:0] target;
      logic [23:0] plen;
      target = 24'h0;
      plen = (24'(pcfg.width) + 24'h1) * 24'(CYC_PER_MS);
      tick = ms_cnt == 24'(CYC_PER_MS - 1);
      next_ms_cnt = tick ? 24'h0 : ms_cnt + 24'h1;
      // After the first loss, re-raise every interval
      if (sig_det[`LOSS_BIT]) begin
         target = 24'(det_interval) * 24'(MS_PER_SEC);
      end else begin
         target = 24'(loss_timeout) * 24'(MS_PER_MIN);
      end
      loss_fire = 1'b0;
      next_loss_ms = loss_ms;
      if (sleep || (!loss_below_i && !sig_det[`LOSS_BIT])) begin
         next_loss_ms = 24'h0;
      end else if (tick) begin
         if (loss_ms + 24'h1 >= target) begin
            loss_fire = 1'b1;
            next_loss_ms = 24'h0;
         end else begin
            next_loss_ms = loss_ms + 24'h1;
         end
      end
      // New events during a pulse are not queued
      next_pstate = pstate;
      next_pcyc = pcyc;
      case (pstate)
         PS_IDLE: begin
            if (trig) begin
               next_pstate = PS_PULSE;
               next_pcyc = 24'h0;
            end
         end
         PS_PULSE: begin
            if (pcyc + 24'h1 >= plen) begin
               if (pcfg.sticky && |(next_int_stat & en_eff)) begin
                  next_pstate = PS_HOLD;
               end else begin
                  next_pstate = PS_IDLE;
               end
            end else begin
               next_pcyc = pcyc + 24'h1;
            end
         end
         PS_HOLD: begin
            if (!(|(next_int_stat & en_eff))) begin
               next_pstate = PS_IDLE;
            end
         end
         default: next_pstate = PS_IDLE;
      endcase
      asserted = next_pstate != PS_IDLE;
      // Pin variant forces open drain; enable mask and power-down also differ
      case (HW_VARIANT ? DRIVE_OPEN : pcfg.drive)
         DRIVE_LOW: begin
            next_int_oe = 1'b1;
            next_int_o = ~asserted;
         end
         DRIVE_OPEN: begin
            next_int_oe = asserted;
            next_int_o = 1'b0;
         end
         default: begin
            next_int_oe = 1'b1;
            next_int_o = asserted;
         end
      endcase
      // Released pin held low by the far side
      next_pdown = HW_VARIANT && !int_oe_o && !int_in_i;
      for (int i = 0; i < NPINS; i++) begin
         next_pin_o[i] = 1'b0;
         next_pin_oe[i] = 1'b0;
         if (pin_cfg[i].int_out) begin
            if (pin_cfg[i].open_drain) begin
               next_pin_oe[i] = asserted;
            end else begin
               next_pin_oe[i] = 1'b1;
               next_pin_o[i] = asserted ^ pin_cfg[i].invert;
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ms_cnt <= 24'h0;
         loss_ms <= 24'h0;
         pcyc <= 24'h0;
         pstate <= PS_IDLE;
         int_o <= 1'b0;
         int_oe_o <= 1'b0;
         pin_o <= '0;
         pin_oe_o <= '0;
         power_down_o <= 1'b0;
      end else begin
         ms_cnt <= next_ms_cnt;
         loss_ms <= next_loss_ms;
         pcyc <= next_pcyc;
         pstate <= next_pstate;
         int_o <= next_int_o;
         int_oe_o <= next_int_oe;
         pin_o <= next_pin_o;
         pin_oe_o <= next_pin_oe;
         power_down_o <= next_pdown;
      end
   end

endmodule

/* sim/adc_event_irq_properties.sv */
// Port-level checks for the event interrupt controller
`timescale 1ns/10ps
`include "adc_irq_defs.svh"
module adc_event_irq_props import adc_irq_pkg::*; #(
   parameter int CYC_PER_MS = 10
) (
   input wire logic clk_i, // Device clock
   input wire logic rstn_i, // Async reset
   input wire logic reg_wr_i, // Write strobe
   input wire logic reg_rd_i, // Read strobe
   input wire logic [7:0] reg_addr_i, // Offset
   input wire logic [7:0] reg_wdata_i, // Write data
   input wire logic [7:0] reg_rdata_o, // Read data
   input wire logic clip_i, // Clip event
   input wire logic int_o, // Pin value
   input wire logic int_oe_o // Pin enable
);
   // ------------------------------
   // Shadow registers and pulse count
   // ------------------------------
   pulse_cfg_type cfg;
   pulse_cfg_type next_cfg;
   logic [7:0] en;
   logic [7:0] next_en;
   logic [1:0] age;
   logic [1:0] next_age;
   logic [6:0] cnt;
   logic [6:0] next_cnt;
   logic act;
   // Asserted level depends on the drive kind
   always_comb begin
      case (cfg.drive)
         DRIVE_LOW: act = !int_o;
         DRIVE_OPEN: act = int_oe_o;
         default: act = int_o;
      endcase
   end
   // Age masks the cycles where the pin lags a drive change
   always_comb begin
      next_cfg = cfg;
      next_en = en;
      next_age = (age == 2'h3) ? age : age + 2'h1;
      next_cnt = act ? cnt + 7'h01 : 7'h00;
      if (reg_wr_i && reg_addr_i == `OFS_PULSE_CONFIG) begin
         next_cfg = pulse_cfg_type'(reg_wdata_i);
         next_age = 2'h0;
      end
      if (reg_wr_i && reg_addr_i == `OFS_INT_ENABLE) begin
         next_en = reg_wdata_i;
      end
   end
   // Register the shadow state
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cfg <= pulse_cfg_type'(`RST_PULSE_CONFIG);
         en <= `RST_INT_ENABLE;
         age <= 2'h0;
         cnt <= 7'h00;
      end else begin
         cfg <= next_cfg;
         en <= next_en;
         age <= next_age;
         cnt <= next_cnt;
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);
   property p_width;
      $fell(act) && age == 2'h3 && !cfg.sticky |->
         cnt == (cfg.width + 1) * CYC_PER_MS;
   endproperty
   a_width: assert property (p_width)
      else $error("interrupt pulse width off");
   property p_max;
      act && !cfg.sticky |-> cnt < 4 * CYC_PER_MS;
   endproperty
   a_max: assert property (p_max)
      else $error("interrupt pin held too long");
   property p_start;
      en[`SRC_CLIP] && $rose(clip_i) && !act && !$past(act) &&
         age == 2'h3 |=> act;
   endproperty
   a_start: assert property (p_start)
      else $error("enabled clip gave no pulse");
   property p_oe;
      age == 2'h3 && cfg.drive != DRIVE_OPEN |-> int_oe_o;
   endproperty
   a_oe: assert property (p_oe)
      else $error("push-pull pin not driven");
   property p_open;
      age == 2'h3 && cfg.drive == DRIVE_OPEN |-> !int_o;
   endproperty
   a_open: assert property (p_open)
      else $error("open drain pin drives high");
   property p_en_read;
      reg_rd_i && !reg_wr_i && reg_addr_i == `OFS_INT_ENABLE |=>
         reg_rdata_o == en;
   endproperty
   a_en_read: assert property (p_en_read)
      else $error("enable register readback wrong");
   property p_unmapped;
      reg_rd_i && reg_addr_i > 8'h70 |=> reg_rdata_o == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_hold;
      !reg_rd_i |=> $stable(reg_rdata_o);
   endproperty
   a_hold: assert property (p_hold)
      else $error("read data changed without read");
   c_open: cover property (act && cfg.drive == DRIVE_OPEN);
   c_long: cover property ($fell(act) && cfg.width == 2'h3);
   c_retrig: cover property (act && $rose(clip_i));
endmodule

/* sim/host_mcu.sv */
// Host controller model on the register port and interrupt line
`timescale 1ns/10ps
module host_mcu (
   input wire logic clk_i, // Device clock
   output logic reg_wr_o, // Write strobe
   output logic reg_rd_o, // Read strobe
   output logic [7:0] reg_addr_o, // Offset
   output logic [7:0] reg_wdata_o, // Write data
   input wire logic [7:0] reg_rdata_i, // Read data
   input wire logic int_i, // Pin value
   input wire logic int_oe_i, // Pin enable
   output logic int_level_o // Resolved line
);
   // Idle bus at time zero
   initial begin
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
   end
   // Pull-up holds a released line high
   assign int_level_o = int_oe_i ? int_i : 1'b1;
   // One-cycle write; released lines show inverted data
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr_o = a;
      reg_wdata_o = d;
      reg_wr_o = 1'b1;
      @(negedge clk_i);
      reg_wr_o = 1'b0;
      reg_addr_o = ~a;
      reg_wdata_o = ~d;
      // Idle cycle: the next strobe never rises where this one fell
      @(negedge clk_i);
   endtask
   // Read data is taken once the registered answer has settled
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      reg_addr_o = a;
      reg_rd_o = 1'b1;
      @(negedge clk_i);
      reg_rd_o = 1'b0;
      reg_addr_o = ~a;
      @(negedge clk_i);
      d = reg_rdata_i;
   endtask
endmodule

/* sim/testbench.sv */
// Self-checking bench for the event interrupt controller
`timescale 1ns/10ps
`include "adc_irq_defs.svh"
bind adc_event_irq adc_event_irq_props #(.CYC_PER_MS(CYC_PER_MS)) u_props (
   .clk_i(clk_i), .rstn_i(rstn_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_rdata_o(reg_rdata_o), .clip_i(clip_i), .int_o(int_o),
   .int_oe_o(int_oe_o));
module testbench import adc_irq_pkg::*;;
   localparam int CPM = 10;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic loss_below = 1'b0;
   logic dc_change = 1'b0;
   logic clip = 1'b0;
   logic [3:0] pins = 4'h0;
   logic reg_wr, reg_rd, int_in, int_o, int_oe_o, sleep_o;
   logic [7:0] reg_addr, reg_wdata, reg_rdata_o;
   logic [3:0] pin_o, pin_oe_o;
   logic power_down_o;
   pin_drive_type drv = DRIVE_HIGH;
   int failures = 0;
   int n_compared = 0;
   adc_event_irq #(.CYC_PER_MS(CPM), .MS_PER_MIN(3), .MS_PER_SEC(2)) DUT (
      .clk_i(clk_i), .rstn_i(rstn_i), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
      .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
      .reg_rdata_o(reg_rdata_o), .audio_clk_run_i(1'b1),
      .loss_below_i(loss_below), .resume_det_i(8'h00),
      .dc_change_i(dc_change), .clip_i(clip), .pin_in_i(pins),
      .int_in_i(int_in), .int_o(int_o), .int_oe_o(int_oe_o),
      .pin_o(pin_o), .pin_oe_o(pin_oe_o), .power_down_o(power_down_o),
      .sleep_o(sleep_o));
   host_mcu host (.clk_i(clk_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
      .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
      .reg_rdata_i(reg_rdata_o), .int_i(int_o), .int_oe_i(int_oe_o),
      .int_level_o(int_in));
   // ------------------------------
   // Clock, checks and scenarios
   // ------------------------------
   always #25 clk_i = ~clk_i;
   // Asserted as seen on the resolved line
   function automatic logic act();
      return (drv == DRIVE_HIGH) ? int_in : !int_in;
   endfunction
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      host.rd(a, d);
      cmp(d, exp);
   endtask
   // Waits up to lim cycles for a pulse, then compares its length
   task automatic pulse(input logic [7:0] exp, input int lim);
      int n;
      int w;
      n = 0;
      w = 0;
      while (!act() && w < lim) begin
         @(negedge clk_i);
         w++;
      end
      while (act() && n < 100) begin
         @(negedge clk_i);
         n++;
      end
      cmp(8'(n), exp);
   endtask
   task automatic s_reset();
      cmp({6'h00, int_oe_o, int_o}, 8'h02);
      cmp({pin_oe_o, pin_o}, 8'h00);
      cmp({7'h00, power_down_o}, 8'h00);
      rchk(`OFS_INT_ENABLE, `RST_INT_ENABLE);
      rchk(`OFS_INT_STATUS, 8'h00);
      rchk(`OFS_SIG_DET_STATUS, 8'h00);
      rchk(`OFS_PULSE_CONFIG, `RST_PULSE_CONFIG);
      rchk(8'h7F, 8'h00);
   endtask
   // A second clip mid-pulse must not stretch the pulse
   task automatic s_clip(input pin_drive_type d, input logic [1:0] w);
      drv = d;
      host.wr(`OFS_PULSE_CONFIG, {4'h0, d, w});
      repeat (3) @(negedge clk_i);
      clip = 1'b1;
      fork
         pulse(8'((w + 1) * CPM), 4);
         begin
            repeat (5) @(negedge clk_i);
            clip = 1'b0;
            repeat (2) @(negedge clk_i);
            clip = 1'b1;
         end
      join
      clip = 1'b0;
      rchk(`OFS_INT_STATUS, 8'h20);
      host.wr(`OFS_INT_STATUS, 8'h20);
      rchk(`OFS_INT_STATUS, 8'h00);
   endtask
   // Clip flag cleared by enable zero-then-one
   task automatic s_clr();
      clip = 1'b1;
      pulse(8'(CPM), 4);
      clip = 1'b0;
      host.wr(`OFS_INT_ENABLE, 8'h01);
      host.wr(`OFS_INT_ENABLE, 8'h21);
      rchk(`OFS_INT_STATUS, 8'h00);
   endtask
   task automatic s_dc();
      host.wr(`OFS_PULSE_CONFIG, 8'h00);
      drv = DRIVE_HIGH;
      s_clr();
      host.wr(`OFS_INT_ENABLE, 8'h01);
      dc_change = 1'b1;
      pulse(8'h00, 8);
      dc_change = 1'b0;
      host.wr(`OFS_INT_ENABLE, 8'h03);
      dc_change = 1'b1;
      pulse(8'(CPM), 4);
      dc_change = 1'b0;
      host.wr(`OFS_INT_STATUS, 8'hFF);
   endtask
   // Loss fires, re-fires, and clears only after detect status
   task automatic s_loss();
      host.wr(`OFS_INT_ENABLE, 8'h01);
      loss_below = 1'b1;
      pulse(8'(CPM), 60);
      pulse(8'(CPM), 40);
      host.wr(`OFS_INT_ENABLE, 8'h00);
      rchk(`OFS_SIG_DET_STATUS, 8'h01);
      host.wr(`OFS_INT_STATUS, 8'h01);
      rchk(`OFS_INT_STATUS, 8'h01);
      loss_below = 1'b0;
      // Second write covers a refire landing on the first
      host.wr(`OFS_SIG_DET_STATUS, 8'hFF);
      host.wr(`OFS_SIG_DET_STATUS, 8'hFF);
      rchk(`OFS_SIG_DET_STATUS, 8'h00);
      host.wr(`OFS_INT_STATUS, 8'h01);
      rchk(`OFS_INT_STATUS, 8'h00);
      host.wr(`OFS_INT_ENABLE, 8'h01);
   endtask
   task automatic s_sleep();
      loss_below = 1'b1;
      pulse(8'(CPM), 60);
      loss_below = 1'b0;
      host.wr(`OFS_INT_ENABLE, 8'h00);
      repeat (12) @(negedge clk_i);
      host.wr(`OFS_POWER_DOWN, 8'h01);
      rchk(`OFS_INT_STATUS, 8'h00);
      rchk(`OFS_SIG_DET_STATUS, 8'h00);
      cmp({7'h00, sleep_o}, 8'h01);
      host.wr(`OFS_PIN_CFG0, 8'h01);
      host.wr(`OFS_PIN_CFG0 + 8'h02, 8'h01);
      host.wr(`OFS_INT_ENABLE, 8'h04);
      pins = 4'h4;
      pulse(8'h00, 8);
      pins = 4'h5;
      pulse(8'(CPM), 6);
      rchk(`OFS_INT_STATUS, 8'h04);
      host.wr(`OFS_INT_STATUS, 8'h04);
      host.wr(`OFS_POWER_DOWN, 8'h00);
      repeat (3) @(negedge clk_i);
      pins = 4'h4;
      pulse(8'h00, 8);
   endtask
   task automatic conclude();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Main sequence after a ten-cycle reset
   initial begin
      repeat (10) @(negedge clk_i);
      rstn_i = 1'b1;
      @(negedge clk_i);
      s_reset();
      host.wr(`OFS_INT_ENABLE, 8'h21);
      for (int d = 0; d < 3; d++) begin
         for (int w = 0; w < 4; w++) begin
            s_clip(pin_drive_type'(d), 2'(w));
         end
      end
      s_dc();
      s_loss();
      s_sleep();
      conclude();
   end
   // Generous limit: the full run needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge clk_i);
      failures++;
      $display("mismatch at %0t: watchdog expired", $time);
      conclude();
   end
endmodule
